// File: verilog/priority_request_unit.sv
// Contract
// R1 - eight request inputs, each bus-vectored or locally vectored
// R2 - inputs marked cascaded take their identifier from a slave unit
// R3 - per-input edge or level trigger; asserted input becomes pending
// R4 - resolved request drives one combined host request line
// R5 - software picks priority mode at run time through control register
// R6 - fixed nested mode ranks input 0 highest, input 7 lowest
// R7 - special nested mode lets serviced cascaded input request again
// R8 - host checks just-serviced slave for pending work before exit
// R9 - auto rotation: serviced level becomes lowest until next interrupt
// R10 - specific rotation: software names lowest, others follow in order
// R11 - special mask mode blocks only levels currently in service
// R12 - poll mode: host request held off, poll read reports serviced level
// R13 - acknowledge delivers 8-bit identifier of interrupting source
// R14 - host multiplies identifier by four to find service routine
// R15 - host's non-maskable input lies outside this unit
// R16 - serial receive-full and transmit-empty can raise requests
// R17 - parallel input-full and output-empty can raise requests
// R18 - eight bus request lines routable to the unit inputs
// R19 - blocked requests stay pending and return once unblocked
`timescale 1ns/10ps
`default_nettype none
`include "pic_map.svh"

module priority_request_unit (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // request sources
  input  wire pic_pkg::source_t src,
  // cascade
  input  wire logic [7:0]       slave_vector,
  // host side
  output logic                  maskable_host_request,
  input  wire logic             host_ack,
  output logic [7:0]            vector_out,
  output logic                  vector_valid,
  // register bus
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // event interrupt
  output logic                  irq
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // rank of a level; 0 is highest, level just after lowest ranks first
  function automatic logic [2:0] rank(input logic [2:0] lvl,
                                      input logic [2:0] low);
    rank = 3'(lvl - low - 3'h1);
  endfunction

  // highest-ranked set bit of a vector
  function automatic pic_pkg::pick_t best(input logic [7:0] vec,
                                          input logic [2:0] low);
    pic_pkg::pick_t p;
    logic [2:0]     l;
    p = '0;
    for (int k = 7; k >= 0; k--) begin
      l = 3'(low + 3'h1 + 3'(k));
      if (vec[l]) begin
        p.found = 1'b1;
        p.level = l;
      end
    end
    best = p;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0]  ctrl_reg;
  logic [7:0]  trig_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  serv_reg;
  logic [7:0]  latch_reg;
  logic [11:0] prev_reg;
  logic [2:0]  lowest_reg;
  logic [4:0]  vbase_reg;
  logic [7:0]  casc_reg;
  logic [31:0] route_reg;
  logic [1:0]  ist_reg;
  logic [1:0]  ien_reg;
  logic [7:0]  raw_in;
  logic [7:0]  edge_in;
  logic [7:0]  pend;
  logic [7:0]  elig;
  logic [11:0] src_vec;
  logic [2:0]  eff_low;
  logic [1:0]  mode;
  logic        poll_mode;
  logic        cand_ok;
  logic        do_ack;
  logic        poll_rd;
  logic        wr_do;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [2:0]  eoi_lvl;
  logic        eoi_do;
  pic_pkg::pick_t cand;
  pic_pkg::pick_t top;

  assign mode      = ctrl_reg[`F_MODE_HI:`F_MODE_LO];          // [R5]
  assign poll_mode = ctrl_reg[`F_POLLMODE];

  // ----------------------------------------------------------------
  // source routing
  // ----------------------------------------------------------------
  assign src_vec = {src.par_out_empty, src.par_in_full,        // [R17]
                    src.ser_tx_empty, src.ser_rx_full,         // [R16]
                    src.bus_vectored_request};                 // [R18]

  always_comb begin
    raw_in = '0;
    for (int i = 0; i < 8; i++) begin
      if (route_reg[4*i +: 4] <= `SRC_PAR_OUT)
        raw_in[i] = src_vec[route_reg[4*i +: 4]];              // [R1]
    end
  end

  // ----------------------------------------------------------------
  // pending requests
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst)
      prev_reg <= '0;
    else
      prev_reg <= {4'h0, raw_in};
  end

  assign edge_in = raw_in & ~prev_reg[7:0] & ~trig_reg;
  assign pend    = (trig_reg & raw_in) | (~trig_reg & latch_reg); // [R3]

  // new edge wins over the clear by acknowledge
  always_ff @(posedge clock) begin
    if (rst)
      latch_reg <= '0;
    else if (do_ack && cand_ok)
      latch_reg <= (latch_reg & ~(8'h01 << cand.level)) | edge_in;
    else
      latch_reg <= latch_reg | edge_in;                        // [R19]
  end

  // ----------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------
  always_comb begin
    if (mode == `MODE_AUTO)
      eff_low = lowest_reg;                                    // [R9] [R10]
    else
      eff_low = `RST_LOWEST;                                   // [R6]
  end

  assign top = best(serv_reg, eff_low);

  always_comb begin
    if (ctrl_reg[`F_SMASK])
      elig = pend & ~mask_reg & ~serv_reg;                     // [R11]
    else
      elig = pend & ~mask_reg;
    cand    = best(elig, eff_low);
    cand_ok = 1'b0;
    if (cand.found) begin
      if (ctrl_reg[`F_SMASK] || !top.found)
        cand_ok = 1'b1;
      else if (rank(cand.level, eff_low) < rank(top.level, eff_low))
        cand_ok = 1'b1;                                        // [R19]
      else if (mode == `MODE_SNESTED && cand.level == top.level &&
               casc_reg[cand.level])
        cand_ok = 1'b1;                                        // [R7]
    end
  end

  assign maskable_host_request = cand_ok & ~poll_mode;         // [R4] [R12]
  assign do_ack  = (host_ack & ~poll_mode) | poll_rd;

  // ----------------------------------------------------------------
  // in-service and rotation
  // ----------------------------------------------------------------
  assign eoi_do  = wr_do && wr_addr == `A_EOI;
  assign eoi_lvl = wr_data[`F_EOI_SPEC] ? wr_data[2:0] : top.level;

  always_ff @(posedge clock) begin
    if (rst) begin
      serv_reg <= '0;
    end else begin
      serv_reg <= (serv_reg &
                  ~((eoi_do && (wr_data[`F_EOI_SPEC] || top.found)) ?
                    (8'h01 << eoi_lvl) : 8'h00)) |
                  ((do_ack && cand_ok) ? (8'h01 << cand.level) : 8'h00);
    end
  end

  always_ff @(posedge clock) begin
    if (rst)
      lowest_reg <= `RST_LOWEST;
    else if (wr_do && wr_addr == `A_LOWEST)
      lowest_reg <= wr_data[2:0];                              // [R10]
    else if (eoi_do && mode == `MODE_AUTO && top.found)
      lowest_reg <= eoi_lvl;                                   // [R9]
  end

  // ----------------------------------------------------------------
  // identifier output
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      vector_out   <= '0;
      vector_valid <= 1'b0;
    end else begin
      vector_valid <= host_ack & ~poll_mode;
      if (host_ack && !poll_mode) begin
        if (cand_ok && casc_reg[cand.level])
          vector_out <= slave_vector;                          // [R2]
        else if (cand_ok)
          vector_out <= {vbase_reg, cand.level};               // [R13]
        else
          vector_out <= {vbase_reg, `RST_LOWEST};
      end
    end
  end

  // ----------------------------------------------------------------
  // event status
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ist_reg <= '0;
    end else begin
      if (wr_do && wr_addr == `A_ICLR)
        ist_reg <= ist_reg & ~wr_data[1:0] |
                   {do_ack & ~cand_ok, do_ack & cand_ok};
      else
        ist_reg <= ist_reg | {do_ack & ~cand_ok, do_ack & cand_ok};
    end
  end

  assign irq = |(ist_reg & ien_reg);

  // ----------------------------------------------------------------
  // register bus: write side
  // ----------------------------------------------------------------
  pic_pkg::wr_state_t wr_state;
  logic               aw_full;
  logic               w_full;
  logic [11:0]        aw_addr_reg;
  logic [31:0]        w_data_reg;
  logic [3:0]         w_strb_reg;
  logic               wr_hit;

  assign s_axi_awready = ~aw_full & (wr_state == pic_pkg::WR_IDLE);
  assign s_axi_wready  = ~w_full & (wr_state == pic_pkg::WR_IDLE);
  assign wr_do   = aw_full & w_full & (wr_state == pic_pkg::WR_IDLE);
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;

  always_comb begin
    wr_hit = 1'b1;
    if (wr_addr == `A_CTRL) wr_hit = 1'b1;
    else if (wr_addr == `A_TRIG) wr_hit = 1'b1;
    else if (wr_addr == `A_MASK) wr_hit = 1'b1;
    else if (wr_addr == `A_EOI) wr_hit = 1'b1;
    else if (wr_addr == `A_LOWEST) wr_hit = 1'b1;
    else if (wr_addr == `A_VBASE) wr_hit = 1'b1;
    else if (wr_addr == `A_CASC) wr_hit = 1'b1;
    else if (wr_addr == `A_ROUTE) wr_hit = 1'b1;
    else if (wr_addr == `A_IEN) wr_hit = 1'b1;
    else if (wr_addr == `A_ICLR) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_state     <= pic_pkg::WR_IDLE;
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else begin
      case (wr_state)
        pic_pkg::WR_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_full     <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[11:2], 2'h0};
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_full     <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
          end
          if (wr_do) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
            wr_state     <= pic_pkg::WR_RESP;
          end
        end
        pic_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state     <= pic_pkg::WR_IDLE;
          end
        end
        default: wr_state <= pic_pkg::WR_IDLE;
      endcase
    end
  end

  // software-written control, low byte lane strobe gates every field, the 32-bit route field too
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg  <= `RST_CTRL;
      trig_reg  <= `RST_TRIG;
      mask_reg  <= `RST_MASK;
      vbase_reg <= `RST_VBASE;
      casc_reg  <= `RST_CASC;
      route_reg <= `RST_ROUTE;
      ien_reg   <= `RST_IEN;
    end else if (wr_do && w_strb_reg[0]) begin
      if (wr_addr == `A_CTRL) ctrl_reg <= wr_data[3:0];        // [R5]
      else if (wr_addr == `A_TRIG) trig_reg <= wr_data[7:0];   // [R3]
      else if (wr_addr == `A_MASK) mask_reg <= wr_data[7:0];
      else if (wr_addr == `A_VBASE) vbase_reg <= wr_data[7:3];
      else if (wr_addr == `A_CASC) casc_reg <= wr_data[7:0];   // [R2]
      else if (wr_addr == `A_ROUTE) route_reg <= wr_data;      // [R18]
      else if (wr_addr == `A_IEN) ien_reg <= wr_data[1:0];
    end
  end

  // ----------------------------------------------------------------
  // register bus: read side
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign poll_rd = s_axi_arvalid & s_axi_arready &
                   ({s_axi_araddr[11:2], 2'h0} == `A_POLL);    // [R12]

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_OKAY;
      s_axi_rdata  <= '0;
      if ({s_axi_araddr[11:2], 2'h0} == `A_CTRL)
        s_axi_rdata <= {28'h0, ctrl_reg};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_TRIG)
        s_axi_rdata <= {24'h0, trig_reg};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_MASK)
        s_axi_rdata <= {24'h0, mask_reg};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_PEND)
        s_axi_rdata <= {24'h0, pend};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_SERV)
        s_axi_rdata <= {24'h0, serv_reg};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_LOWEST)
        s_axi_rdata <= {29'h0, lowest_reg};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_VBASE)
        s_axi_rdata <= {24'h0, vbase_reg, 3'h0};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_POLL)
        s_axi_rdata <= {24'h0, cand_ok, 4'h0, cand.level};     // [R12]
      else if ({s_axi_araddr[11:2], 2'h0} == `A_CASC)
        s_axi_rdata <= {24'h0, casc_reg};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_ROUTE)
        s_axi_rdata <= route_reg;
      else if ({s_axi_araddr[11:2], 2'h0} == `A_IST)
        s_axi_rdata <= {30'h0, ist_reg};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_IEN)
        s_axi_rdata <= {30'h0, ien_reg};
      else if ({s_axi_araddr[11:2], 2'h0} == `A_EOI ||
               {s_axi_araddr[11:2], 2'h0} == `A_ICLR)
        s_axi_rdata <= '0;
      else
        s_axi_rresp <= `AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: verilog/pic_map.svh
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

// register byte addresses
`define A_CTRL     12'h000
`define A_TRIG     12'h004
`define A_MASK     12'h008
`define A_PEND     12'h00C
`define A_SERV     12'h010
`define A_EOI      12'h014
`define A_LOWEST   12'h018
`define A_VBASE    12'h01C
`define A_POLL     12'h020
`define A_CASC     12'h024
`define A_ROUTE    12'h028
`define A_IST      12'h02C
`define A_IEN      12'h030
`define A_ICLR     12'h034

// control register and EOI write fields
`define F_MODE_HI   1
`define F_MODE_LO   0
`define F_SMASK     2
`define F_POLLMODE  3
`define F_EOI_SPEC  3

// priority modes held in the control register
`define MODE_NESTED  2'h0
`define MODE_SNESTED 2'h1
`define MODE_AUTO    2'h2

// reset values
`define RST_CTRL   4'h0
`define RST_TRIG   8'h00
`define RST_MASK   8'hFF
`define RST_LOWEST 3'h7
`define RST_VBASE  5'h00
`define RST_CASC   8'h00
`define RST_ROUTE  32'h7654_3210
`define RST_IEN    2'h0

// source selector codes
`define SRC_SER_RX  4'h8
`define SRC_SER_TX  4'h9
`define SRC_PAR_IN  4'hA
`define SRC_PAR_OUT 4'hB

// event bits
`define EV_TAKEN    0
`define EV_SPUR     1

`define AXI_OKAY   2'h0
`define AXI_SLVERR 2'h2

`endif

// File: verilog/pic_pkg.sv
`default_nettype none

package pic_pkg;

  // on-board and bus request sources
  typedef struct packed {
    logic       ser_rx_full;
    logic       ser_tx_empty;
    logic       par_in_full;
    logic       par_out_empty;
    logic [7:0] bus_vectored_request;
  } source_t;

  // resolver result
  typedef struct packed {
    logic       found;
    logic [2:0] level;
  } pick_t;

  // register bus write-side state
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

endpackage

`default_nettype wire

// File: bench/pic_checker_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "pic_map.svh"

module pic_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // host side
  input wire logic        host_ack,
  input wire logic [7:0]  vector_out,
  input wire logic        vector_valid,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  // ------------------------------------------
  // bus and vector relations
  // ------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answered: assert property (s_wr_taken
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answered: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_held_off: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_held_off: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_resp_legal: assert property (s_axi_bvalid |->
    s_axi_bresp inside {`AXI_OKAY, `AXI_SLVERR})
    else $error("bad write response");
  a_vector_cause: assert property (vector_valid |-> $past(host_ack))
    else $error("vector without acknowledge");
  a_vector_pulse: assert property (vector_valid |=> !vector_valid)
    else $error("vector valid too long");
  a_vector_moves: assert property ($changed(vector_out)
    |-> vector_valid)
    else $error("vector changed without valid");
endmodule

bind priority_request_unit pic_checker chk_i (.clock, .rst, .host_ack,
  .vector_out, .vector_valid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);
`default_nettype wire

// File: bench/host_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // controller side
  input  wire logic       maskable_host_request,
  input  wire logic       vector_valid,
  input  wire logic [7:0] vector_out,
  output logic            host_ack,
  // bench control
  input  wire logic       en,
  input  wire logic       blind,
  input  wire logic       nmi_request,
  output logic [7:0]      n_vec,
  output logic [7:0]      last_vector,
  output logic [9:0]      pointer,
  output logic            nmi_seen
);
  // ------------------------------------------
  // one acknowledge for each enable
  // ------------------------------------------
  logic busy;
  always_ff @(posedge clock) begin
    if (rst) begin
      host_ack <= 1'b0;
      busy     <= 1'b0;
    end else begin
      host_ack <= en && !busy && (maskable_host_request || blind);
      if (!en) begin
        busy <= 1'b0;
      end else if (maskable_host_request || blind) begin
        busy <= 1'b1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      n_vec <= 8'h00;
    end else if (vector_valid) begin
      n_vec       <= n_vec + 8'h01;
      last_vector <= vector_out;
      pointer     <= {vector_out, 2'b00};
    end
  end
  // non-maskable path bypasses the controller
  always_ff @(posedge clock) begin
    nmi_seen <= nmi_request;
  end
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pic_map.svh"

module tb;
  // ------------------------------------------
  // signals and instances
  // ------------------------------------------
  logic clock = 1'b0, rst = 1'b1, host_ack, vector_valid, irq;
  logic maskable_host_request, en = 1'b0, blind = 1'b0;
  logic [7:0] vector_out, n_vec, last_vector, slave_vector = 8'h99;
  logic [9:0] pointer;
  logic nmi = 1'b0, nmi_seen;
  pic_pkg::source_t src = 12'h000;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_mismatch = 0, n_tests = 0, cycles = 0;
  logic [11:0] ra [8] = '{`A_CTRL, `A_TRIG, `A_MASK, `A_LOWEST, `A_VBASE,
                          `A_CASC, `A_ROUTE, `A_IEN};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'hFF, 32'h7, 32'h0, 32'h0,
                          32'h7654_3210, 32'h0};
  logic [11:0] sv [5] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h010};

  priority_request_unit dut (.clock, .rst, .src, .slave_vector,
    .maskable_host_request, .host_ack, .vector_out, .vector_valid,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq);
  host_model host (.clock, .rst, .maskable_host_request, .vector_valid,
    .vector_out, .host_ack, .en, .blind, .nmi_request(nmi), .n_vec,
    .last_vector, .pointer, .nmi_seen);

  always #2.5 clock = ~clock;
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [1:0] resp_of(input logic [11:0] a);
    return (a > `A_ICLR) ? `AXI_SLVERR : `AXI_OKAY;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", resp_of(a), s_axi_bresp);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", resp_of(a), s_axi_rresp);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic set_src(input logic [11:0] v);
    @(posedge clock);
    src <= v;
    repeat (3) @(posedge clock);
  endtask
  task automatic take(input logic [7:0] e);
    logic [7:0] c;
    @(posedge clock);
    en <= 1'b1;
    c = n_vec;
    do @(posedge clock); while (n_vec === c);
    en <= 1'b0;
    chk("vector", {24'h0, e}, {24'h0, last_vector});
    chk("pointer", 32'(e) * 32'h4, {22'h0, pointer});
  endtask
  task automatic test_done(input string n);
    $display("test %s done, mismatches so far %0d", n, n_mismatch);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  // ------------------------------------------
  // tests
  // ------------------------------------------
  initial begin
    logic [31:0] d;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    foreach (ra[i]) rdc(ra[i], rv[i]);
    rd(12'h3F0, d);
    wr(12'h3F0, 32'h1);
    chk("host_req", 0, maskable_host_request);
    test_done("reset");
    wr(`A_VBASE, 32'h40); wr(`A_MASK, 32'h0); wr(`A_IEN, 32'h3);
    set_src(12'h084);
    take(8'h42);
    chk("host_req", 0, maskable_host_request);
    rdc(`A_PEND, 32'h80);
    rdc(`A_SERV, 32'h04);
    wr(`A_EOI, 32'h0);
    take(8'h47);
    wr(`A_EOI, 32'h0);
    rdc(`A_PEND, 32'h0);
    set_src(12'h000);
    chk("irq", 1, irq);
    rdc(`A_IST, 32'h1); wr(`A_ICLR, 32'h1); rdc(`A_IST, 32'h0);
    chk("irq", 0, irq);
    wr(`A_MASK, 32'h1); set_src(12'h001);
    chk("host_req", 0, maskable_host_request);
    wr(`A_MASK, 32'h0);
    take(8'h40);
    wr(`A_EOI, 32'h0); set_src(12'h000);
    test_done("nested");
    wr(`A_TRIG, 32'hFF); wr(`A_CTRL, 32'h2); set_src(12'h009);
    take(8'h40); wr(`A_EOI, 32'h0);
    rdc(`A_LOWEST, 32'h0);
    take(8'h43); wr(`A_EOI, 32'h0);
    take(8'h40); wr(`A_EOI, 32'h0);
    wr(`A_LOWEST, 32'h4); set_src(12'h048);
    take(8'h46); wr(`A_EOI, 32'h0);
    test_done("rotation");
    wr(`A_CTRL, 32'h4); set_src(12'h008);
    take(8'h43);
    set_src(12'h028);
    take(8'h45);
    rdc(`A_SERV, 32'h28);
    set_src(12'h000); wr(`A_EOI, 32'hD);
    rdc(`A_SERV, 32'h08);
    wr(`A_EOI, 32'h0);
    rdc(`A_SERV, 32'h0);
    test_done("special mask");
    wr(`A_TRIG, 32'h0); wr(`A_CTRL, 32'h1); wr(`A_CASC, 32'h2);
    set_src(12'h002);
    take(8'h99);
    set_src(12'h000); set_src(12'h002);
    take(8'h99);
    rdc(`A_PEND, 32'h0);
    wr(`A_EOI, 32'h0); wr(`A_EOI, 32'h0); set_src(12'h000);
    test_done("cascade");
    wr(`A_CTRL, 32'h8); wr(`A_CASC, 32'h0); set_src(12'h020);
    chk("host_req", 0, maskable_host_request);
    rdc(`A_POLL, 32'h85);
    rdc(`A_SERV, 32'h20);
    wr(`A_EOI, 32'h0); set_src(12'h000);
    test_done("poll");
    wr(`A_CTRL, 32'h0); wr(`A_TRIG, 32'hFF); wr(`A_ROUTE, 32'h7654_BA98);
    foreach (sv[i]) begin
      set_src(sv[i]);
      rdc(`A_PEND, 32'h1 << i);
    end
    set_src(12'h000);
    test_done("routing");
    wr(`A_ICLR, 32'h3); blind <= 1'b1;
    take(8'h47);
    blind <= 1'b0;
    rdc(`A_IST, 32'h2);
    wr(`A_IEN, 32'h0);
    chk("irq", 0, irq);
    wr(`A_IEN, 32'h2);
    chk("irq", 1, irq);
    wr(`A_ICLR, 32'h2);
    chk("irq", 0, irq);
    nmi <= 1'b1;
    repeat (2) @(posedge clock);
    chk("nmi", 1, nmi_seen);
    chk("host_req", 0, maskable_host_request);
    nmi <= 1'b0;
    test_done("events");
    final_report;
  end
endmodule
`default_nettype wire
